// file: shared/dhp_consts.vh
/*
 constants for the host bus port: address map, field positions, reset values.
 assumes inclusion by design files of the host bus port only.
*/
`ifndef DHP_CONSTS_VH
`define DHP_CONSTS_VH
// ==========================================
// address map (word index on 16-bit bus)
`define DHP_ADDR_W        5
`define DHP_WADDR_RAM_LO  4'h0
`define DHP_WADDR_RAM_HI  4'h7
`define DHP_WADDR_CFG     4'h8
`define DHP_WADDR_IEN     4'h9
`define DHP_WADDR_ISTAT   4'ha
`define DHP_WADDR_FIFO    4'hf
// ==========================================
// field positions
`define DHP_CFG_SYNC_DIR  10
`define DHP_IEN_CNT_LSB   11
`define DHP_IEN_CNT_MSB   15
`define DHP_IRQ_FIFO_BIT  2
`define DHP_IRQ_SEQ_BIT   3
// ==========================================
// reset values
`define DHP_CFG_RST       16'h0000
`define DHP_IEN_RST       16'h0000
// ==========================================
// sizes
`define DHP_FIFO_DEPTH    8
`define DHP_FIFO_AW       3
`define DHP_DATA_W        16
`endif

// file: verilog/dhp_sync2.v
/*
 two flip-flop synchroniser for a vector of asynchronous levels.
 assumes each bit is an independent level; no bus coherency across bits.
*/
`timescale 1ns/1ps
module dhp_sync2 #(
   parameter W = 1
) (
   // clock and reset
   input  wire         clk_sys,
   input  wire         sys_rst,
   // levels
   input  wire [W-1:0] d_in,
   output reg  [W-1:0] d_out
);
   reg [W-1:0] meta_q;
   // ==========================================
   // stage pair, first stage read only by second
   always @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         meta_q <= {W{1'b0}};
         d_out  <= {W{1'b0}};
      end else begin
         meta_q <= d_in;
         d_out  <= meta_q;
      end
   end
endmodule // dhp_sync2

// file: verilog/dhp_fifo.v
/*
 conversion result fifo with valid/ready on both sides.
 assumes a single clock; count output feeds the request threshold logic.
*/
`timescale 1ns/1ps
module dhp_fifo #(
   parameter W  = 16,
   parameter D  = 8,
   parameter AW = 3
) (
   // clock and reset
   input  wire          clk_sys,
   input  wire          sys_rst,
   // fill side
   input  wire          in_valid,
   output wire          in_ready,
   input  wire [W-1:0]  in_data,
   // drain side
   output wire          out_valid,
   input  wire          out_ready,
   output wire [W-1:0]  out_data,
   // level
   output reg  [AW:0]   count
);
   reg [W-1:0]  mem [0:D-1];
   reg [AW-1:0] wp_q;
   reg [AW-1:0] rp_q;
   wire         push;
   wire         pop;
   assign in_ready  = (count != D[AW:0]);
   assign out_valid = (count != {(AW+1){1'b0}});
   assign out_data  = mem[rp_q];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;
   // ==========================================
   // pointers and level
   always @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         wp_q  <= {AW{1'b0}};
         rp_q  <= {AW{1'b0}};
         count <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wp_q <= wp_q + 1'b1;
         end
         if (pop) begin
            rp_q <= rp_q + 1'b1;
         end
         if (push & ~pop) begin
            count <= count + 1'b1;
         end else if (pop & ~push) begin
            count <= count - 1'b1;
         end
      end
   end
   // ==========================================
   // storage, no reset so it maps to ram
   always @(posedge clk_sys) begin
      if (push) begin
         mem[wp_q] <= in_data;
      end
   end
endmodule // dhp_fifo

// file: verilog/dhp_host_port.v
/*
 processor-facing bus port: strobes, address latch, register and fifo access,
 sync pin, interrupt and transfer request.
 assumes host strobes are asynchronous to clk_sys and slow against it; the
 converter core delivers results on res_valid and is stalled via core_run.
*/
`timescale 1ns/1ps
`include "dhp_consts.vh"
module dhp_host_port (
   // clock and reset
   input  wire        clk_sys,
   input  wire        sys_rst,
   // host bus pins
   input  wire        cs_n,
   input  wire        rd_n,
   input  wire        wr_n,
   input  wire        ale,
   input  wire        bus_width_select,
   input  wire [4:0]  addr_lines,
   input  wire [15:0] data_lines_in,
   output reg  [15:0] data_lines_out,
   output reg  [15:0] data_lines_oe,
   // sync pin
   input  wire        sync_in,
   output reg         sync_out,
   output reg         sync_oe,
   // host outputs
   output reg         int_n,
   output reg         transfer_request,
   // converter core side
   input  wire        res_valid,
   output wire        res_ready,
   input  wire [15:0] res_data,
   input  wire [7:0]  irq_events,
   input  wire        op_done,
   output reg         op_start,
   output reg         core_run,
   output reg         hold
);
   // ==========================================
   // synchronised pins
   wire        cs_s;
   wire        rd_s;
   wire        wr_s;
   wire        ale_s;
   wire        bw_s;
   wire        sync_s;
   wire [4:0]  addr_s;
   wire [15:0] din_s;
   dhp_sync2 #(.W(6)) u_sync_ctl (
      .clk_sys (clk_sys),
      .sys_rst (sys_rst),
      .d_in    ({~cs_n, ~rd_n, ~wr_n, ale, bus_width_select, sync_in}),
      .d_out   ({cs_s, rd_s, wr_s, ale_s, bw_s, sync_s})
   );
   dhp_sync2 #(.W(21)) u_sync_dat (
      .clk_sys (clk_sys),
      .sys_rst (sys_rst),
      .d_in    ({addr_lines, data_lines_in}),
      .d_out   ({addr_s, din_s})
   );
   // ==========================================
   // state
   reg [4:0]  addr_q;
   reg        cs_lat_q;
   reg        ale_q;
   reg        rd_q;
   reg        wr_q;
   reg        sync_q;
   reg [15:0] cfg_q;
   reg [15:0] ien_q;
   reg [7:0]  ist_q;
   reg [15:0] ram_q [0:7];
   reg [7:0]  wlo_q;
   reg        busy_q;
   reg        pend_q;
   wire       fifo_valid;
   wire [15:0] fifo_data;
   wire [3:0] fifo_cnt;
   reg        fifo_pop;
   // ==========================================
   // address latch: transparent while strobe high, frozen while low
   wire [4:0] addr_eff = ale_s ? addr_s : addr_q;
   wire       cs_eff   = ale_s ? cs_s   : cs_lat_q;
   wire       rd_acc   = rd_s & cs_eff;
   wire       wr_acc   = wr_s & cs_eff;
   // word index of an access; byte select on narrow bus
   function [3:0] word_idx;
      input [4:0] a;
      input       bw;
      begin
         word_idx = bw ? a[4:1] : a[4:1];
      end
   endfunction
   wire [3:0] widx  = word_idx(addr_eff, bw_s);
   wire       bhi   = bw_s & addr_eff[0];
   // ==========================================
   // read data selection
   reg [15:0] rdat;
   always @* begin
      rdat = 16'h0000;
      if (widx <= `DHP_WADDR_RAM_HI) begin
         rdat = ram_q[widx[2:0]];
      end else begin
         case (widx)
            `DHP_WADDR_CFG:   rdat = cfg_q;
            `DHP_WADDR_IEN:   rdat = ien_q;
            `DHP_WADDR_ISTAT: rdat = {8'h00, ist_q};
            `DHP_WADDR_FIFO:  rdat = fifo_data;
            default:          rdat = 16'h0000;
         endcase
      end
   end
   wire rd_end = rd_q & ~rd_acc;
   wire wr_end = wr_q & ~wr_acc;
   // ==========================================
   // bus side sequential logic
   integer i;
   always @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         addr_q         <= 5'h00;
         cs_lat_q       <= 1'b0;
         ale_q          <= 1'b1;
         rd_q           <= 1'b0;
         wr_q           <= 1'b0;
         cfg_q          <= `DHP_CFG_RST;
         ien_q          <= `DHP_IEN_RST;
         ist_q          <= 8'h00;
         wlo_q          <= 8'h00;
         data_lines_out <= 16'h0000;
         data_lines_oe  <= 16'h0000;
         fifo_pop       <= 1'b0;
         for (i = 0; i < 8; i = i + 1) begin
            ram_q[i] <= 16'h0000;
         end
      end else begin
         ale_q    <= ale_s;
         rd_q     <= rd_acc;
         wr_q     <= wr_acc;
         fifo_pop <= 1'b0;
         if (ale_q & ~ale_s & cs_s) begin
            addr_q   <= addr_s;
            cs_lat_q <= cs_s;
         end else if (ale_s) begin
            addr_q   <= addr_s;
            cs_lat_q <= cs_s;
         end
         // drivers on only while read and select are both low
         if (rd_acc) begin
            data_lines_out <= bhi ? {8'h00, rdat[15:8]} : rdat;
            data_lines_oe  <= bw_s ? 16'h00ff : 16'hffff;
         end else begin
            data_lines_oe  <= 16'h0000;
         end
         // event set wins over the read clear
         if (rd_end && widx == `DHP_WADDR_ISTAT) begin
            ist_q <= irq_events;
         end else begin
            ist_q <= ist_q | irq_events;
         end
         if (rd_end && widx == `DHP_WADDR_FIFO && (~bw_s | addr_eff[0])) begin
            fifo_pop <= 1'b1;
         end
         // narrow bus: low byte held until the high byte completes the word
         if (wr_end) begin
            if (bw_s & ~addr_eff[0]) begin
               wlo_q <= din_s[7:0];
            end else if (widx <= `DHP_WADDR_RAM_HI) begin
               ram_q[widx[2:0]] <= bw_s ? {din_s[7:0], wlo_q} : din_s;
            end else if (widx == `DHP_WADDR_CFG) begin
               cfg_q <= bw_s ? {din_s[7:0], wlo_q} : din_s;
            end else if (widx == `DHP_WADDR_IEN) begin
               ien_q <= bw_s ? {din_s[7:0], wlo_q} : din_s;
            end
         end
      end
   end
   // ==========================================
   // fifo: core stalls when full
   dhp_fifo #(.W(`DHP_DATA_W), .D(`DHP_FIFO_DEPTH), .AW(`DHP_FIFO_AW)) u_fifo (
      .clk_sys   (clk_sys),
      .sys_rst   (sys_rst),
      .in_valid  (res_valid & core_run),
      .in_ready  (res_ready),
      .in_data   (res_data),
      .out_valid (fifo_valid),
      .out_ready (fifo_pop),
      .out_data  (fifo_data),
      .count     (fifo_cnt)
   );
   // ==========================================
   // sync pin, sequencing, outputs
   wire sync_dir = cfg_q[`DHP_CFG_SYNC_DIR];
   wire [4:0] dma_cnt = ien_q[`DHP_IEN_CNT_MSB:`DHP_IEN_CNT_LSB];
   always @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         sync_q           <= 1'b0;
         sync_out         <= 1'b0;
         sync_oe          <= 1'b0;
         int_n            <= 1'b1;
         transfer_request <= 1'b0;
         op_start         <= 1'b0;
         core_run         <= 1'b1;
         hold             <= 1'b0;
         busy_q           <= 1'b0;
         pend_q           <= 1'b0;
      end else begin
         sync_q   <= sync_s;
         op_start <= 1'b0;
         // select low freezes the core; a pending start waits for release
         core_run <= ~cs_s;
         sync_oe  <= sync_dir;
         if (~sync_dir & sync_s & ~sync_q) begin
            hold   <= 1'b1;
            pend_q <= 1'b1;
         end else if (pend_q & core_run) begin
            op_start <= 1'b1;
            pend_q   <= 1'b0;
            busy_q   <= 1'b1;
         end else if (op_done & busy_q) begin
            busy_q <= 1'b0;
            hold   <= 1'b0;
         end
         sync_out <= sync_dir & (busy_q | op_start) & ~(op_done & busy_q);
         int_n    <= ~|(ist_q & ien_q[7:0]);
         if (fifo_cnt == 4'h0) begin
            transfer_request <= 1'b0;
         end else if ({1'b0, fifo_cnt} == dma_cnt) begin
            transfer_request <= 1'b1;
         end
      end
   end
endmodule // dhp_host_port

// file: test/dhp_host_port_asserts.sv
/*
 pin-level assertions for the host bus port.
 assumes the bind in the bench top file.
*/
`timescale 1ns/1ps
module dhp_host_port_asserts (
   // clock and reset
   input wire        clk_sys,
   input wire        sys_rst,
   // host bus
   input wire        cs_n,
   input wire        rd_n,
   input wire        ale,
   input wire        bus_width_select,
   input wire [15:0] data_lines_oe,
   // sync and flags
   input wire        sync_in,
   input wire        sync_oe,
   input wire        int_n,
   input wire        transfer_request,
   input wire        core_run,
   input wire        hold,
   input wire        op_start
);
   // ==========================================
   // read idle count: flags may drop only soon after a read
   reg [3:0] rd_idle_q;
   always @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) rd_idle_q <= 4'h0;
      else if (!rd_n) rd_idle_q <= 4'h0;
      else if (rd_idle_q != 4'hf) rd_idle_q <= rd_idle_q + 4'h1;
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   sequence rd_on;
      (!rd_n && !cs_n)[*4];
   endsequence
   // ==========================================
   // properties
   chk_oe_needs_rd: assert property (|data_lines_oe |-> !$past(rd_n, 2) || !$past(rd_n, 3))
      else $error("data lines driven without read");
   chk_oe_read_on: assert property (rd_on |-> data_lines_oe[7:0] == 8'hff)
      else $error("low data lines not driven in read");
   chk_bw_upper_off: assert property (bus_width_select && $past(bus_width_select, 4)
      |-> data_lines_oe[15:8] == 8'h00)
      else $error("upper lines driven on 8-bit bus");
   chk_core_halt: assert property ((!cs_n && ale)[*4] |-> !core_run)
      else $error("core runs while selected");
   chk_core_resume: assert property ((cs_n && ale)[*4] |-> core_run)
      else $error("core stalled while deselected");
   chk_sync_hold: assert property (!sync_oe && $rose(sync_in) |-> ##[1:4] hold)
      else $error("sync edge gave no hold");
   chk_hold_start: assert property ($rose(hold) |-> ##[0:2] op_start)
      else $error("no start after hold");
   chk_sync_rst_in: assert property ($past(sys_rst) |-> !sync_oe)
      else $error("sync driven after reset");
   chk_int_stays: assert property (!int_n && rd_idle_q > 4'h8 |=> !int_n)
      else $error("interrupt dropped without read");
   chk_req_stays: assert property (transfer_request && rd_idle_q > 4'h8
      |=> transfer_request)
      else $error("request dropped without read");
endmodule // dhp_host_port_asserts

// file: test/dhp_host_model.sv
/*
 host bus controller model: one access task, plain or latched address.
 assumes its caller starts accesses after the reset release.
*/
`timescale 1ns/1ps
module dhp_host_model (
   // clock
   input  wire         clk_sys,
   // host bus
   output logic        cs_n,
   output logic        rd_n,
   output logic        wr_n,
   output logic        ale,
   output logic [4:0]  addr_lines,
   output logic [15:0] data_lines_in
);
   initial begin
      {cs_n, rd_n, wr_n, ale} = 4'hf;
      addr_lines = 5'h00;
      data_lines_in = 16'h0000;
   end
   // ==========================================
   // m: latch address on ale fall; w: write
   task automatic acc(input logic m, w, input logic [4:0] a, input logic [15:0] d);
      @(negedge clk_sys);
      addr_lines = a;
      data_lines_in = d;
      cs_n = 1'b0;
      if (m) begin
         repeat (4) @(negedge clk_sys);
         ale = 1'b0;
         repeat (4) @(negedge clk_sys);
         addr_lines = ~a;
      end
      @(negedge clk_sys);
      rd_n = w;
      wr_n = ~w;
      repeat (6) @(negedge clk_sys);
      {rd_n, wr_n} = 2'h3;
      @(negedge clk_sys);
      cs_n = 1'b1;
      ale = 1'b1;
      // data and address outlive the strobe, since the port sees it two flops late
      repeat (3) @(negedge clk_sys);
      addr_lines = ~addr_lines;
      data_lines_in = ~d;
      @(negedge clk_sys);
   endtask
endmodule // dhp_host_model

// file: test/dhp_host_port_tb_top.sv
/*
 bench top: host model, core side stimulus, queued read checks.
 assumes design, checker and host model compiled before this file.
*/
`timescale 1ns/1ps
module dhp_host_port_tb_top;
   logic        clk_sys = 1'b0, sys_rst = 1'b1, bus_width_select = 1'b0;
   logic        sync_in = 1'b0, res_valid = 1'b0, op_done = 1'b0, seen = 1'b0;
   logic [15:0] res_data = 16'h0000, e, eq[$], mq[$], fq[$];
   logic [7:0]  irq_events = 8'h00, rnd = 8'h2b;
   wire         cs_n, rd_n, wr_n, ale, res_ready, sync_out, sync_oe, int_n;
   wire         transfer_request, op_start, core_run, hold;
   wire  [4:0]  addr_lines;
   wire  [15:0] data_lines_in, data_lines_out, data_lines_oe;
   int          err_total = 0, checks = 0, i;
   always #5 clk_sys = ~clk_sys;
   dhp_host_model hb (.clk_sys(clk_sys), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .ale(ale),
      .addr_lines(addr_lines), .data_lines_in(data_lines_in));
   dhp_host_port dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .cs_n(cs_n), .rd_n(rd_n),
      .wr_n(wr_n), .ale(ale), .bus_width_select(bus_width_select), .addr_lines(addr_lines),
      .data_lines_in(data_lines_in), .data_lines_out(data_lines_out),
      .data_lines_oe(data_lines_oe), .sync_in(sync_in), .sync_out(sync_out),
      .sync_oe(sync_oe), .int_n(int_n), .transfer_request(transfer_request),
      .res_valid(res_valid), .res_ready(res_ready), .res_data(res_data),
      .irq_events(irq_events), .op_done(op_done), .op_start(op_start),
      .core_run(core_run), .hold(hold));
   // ==========================================
   // helpers
   function automatic logic [7:0] lf(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   task automatic ck(input logic [15:0] x, s, input string n);
      checks++;
      if (s !== x) begin
         err_total++;
         $display("unexpected %s: expected %h seen %h", n, x, s);
      end
   endtask
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge clk_sys);
   endtask
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      hb.acc(1'b0, 1'b1, a, d);
   endtask
   task automatic rd(input logic [4:0] a, input logic [15:0] x, m);
      eq.push_back(x & m);
      mq.push_back(m);
      hb.acc(1'b0, 1'b0, a, 16'h0000);
   endtask
   // ==========================================
   // read monitor: oldest note against the first driven cycle
   always @(negedge clk_sys) begin
      if (data_lines_oe[0] === 1'b1 && !seen && eq.size() > 0) begin
         e = mq.pop_front();
         ck(eq.pop_front(), data_lines_out & data_lines_oe & e, "read data");
      end
      seen = (data_lines_oe[0] === 1'b1);
   end
   initial begin
      #200000;
      err_total++;
      print_verdict;
   end
   // ==========================================
   // scenarios
   initial begin
      tick(4);
      sys_rst = 1'b0;
      ck(16'h0003, {12'h000, sync_oe, transfer_request, int_n, core_run}, "reset");
      tick(3);
      wr(5'h10, 16'h0300);
      rd(5'h10, 16'h0300, 16'hffff);
      wr(5'h12, 16'h2107);
      rd(5'h12, 16'h2107, 16'hffff);
      wr(5'h16, 16'hffff);
      rd(5'h16, 16'h0000, 16'hffff);
      bus_width_select = 1'b1;
      tick(4);
      wr(5'h12, 16'h77ff);
      wr(5'h13, 16'h8818);
      rd(5'h13, 16'h0018, 16'hffff);
      rd(5'h12, 16'h00ff, 16'hffff);
      bus_width_select = 1'b0;
      tick(4);
      rd(5'h12, 16'h18ff, 16'hffff);
      $display("end registers");
      res_valid = 1'b1;
      for (i = 0; i < 8; i++) begin
         rnd = lf(rnd);
         res_data = {rnd, ~rnd};
         fq.push_back(res_data);
         ck(16'h0001, {15'h0000, res_ready}, "fifo ready");
         if (i == 2) ck(16'h0000, {15'h0000, transfer_request}, "early request");
         tick(1);
      end
      rnd = lf(rnd);
      res_data = {rnd, ~rnd};
      tick(3);
      ck(16'h0002, {14'h0000, transfer_request, res_ready}, "full");
      res_valid = 1'b0;
      for (i = 0; i < 8; i++) begin
         if (i == 7) ck(16'h0001, {15'h0000, transfer_request}, "request held");
         rd(5'h1e, fq.pop_front(), 16'hffff);
      end
      tick(2);
      ck(16'h0000, {15'h0000, transfer_request}, "request drop");
      $display("end fifo");
      rd(5'h14, 16'h0000, 16'hffff);
      for (i = 0; i < 8; i++) begin
         irq_events = 8'h01 << i;
         tick(1);
         irq_events = 8'h00;
         tick(3);
         ck(16'h0000, {15'h0000, int_n}, "int set");
         rd(5'h14, 16'h0001 << i, 16'h00ff);
         tick(2);
         ck(16'h0001, {15'h0000, int_n}, "int clear");
      end
      wr(5'h12, 16'h1800);
      irq_events = 8'hff;
      tick(1);
      irq_events = 8'h00;
      tick(4);
      ck(16'h0001, {15'h0000, int_n}, "int masked");
      $display("end interrupts");
      sync_in = 1'b1;
      tick(5);
      ck(16'h0001, {15'h0000, hold}, "hold");
      wr(5'h10, 16'h0400);
      tick(2);
      ck(16'h0007, {13'h0000, sync_oe, sync_out, hold}, "sync busy");
      op_done = 1'b1;
      tick(1);
      op_done = 1'b0;
      sync_in = 1'b0;
      tick(2);
      ck(16'h0004, {13'h0000, sync_oe, sync_out, hold}, "sync out");
      hb.acc(1'b1, 1'b1, 5'h10, 16'h0700);
      rd(5'h10, 16'h0700, 16'hffff);
      sys_rst = 1'b1;
      tick(1);
      ck(16'h0000, {15'h0000, sync_oe}, "sync reset");
      sys_rst = 1'b0;
      tick(3);
      rd(5'h10, 16'h0000, 16'hffff);
      ck(16'h0000, 16'(eq.size()), "reads left");
      $display("end sync and latch");
      print_verdict;
   end
endmodule // dhp_host_port_tb_top

bind dhp_host_port dhp_host_port_asserts u_chk (.clk_sys(clk_sys), .sys_rst(sys_rst),
   .cs_n(cs_n), .rd_n(rd_n), .ale(ale), .bus_width_select(bus_width_select),
   .data_lines_oe(data_lines_oe), .sync_in(sync_in), .sync_oe(sync_oe), .int_n(int_n),
   .transfer_request(transfer_request), .core_run(core_run), .hold(hold),
   .op_start(op_start));
